// File: inc/led_meas_params.svh
// Constants of the slot register slice: indices, fields, resets, masks.
// Assumes the includer turns an index into a byte address (index * 4).
`ifndef LED_MEAS_PARAMS_SVH
`define LED_MEAS_PARAMS_SVH

// ----------
// Register indices (byte address is index * 4)
// ----------
`define IDX_SLOT1_LED_B_CURRENT 6'h26
`define IDX_DRIVE_STATUS 6'h27
`define IDX_SLOT2_SELECTS 6'h28
`define IDX_SLOT2_CONFIG_ONE 6'h29
`define IDX_SLOT2_CONFIG_TWO 6'h2A
`define IDX_SLOT2_CONFIG_THREE 6'h2B
`define IDX_SLOT2_CONFIG_FOUR 6'h2C
`define IDX_SLOT2_LED_A_CURRENT 6'h2D

// ----------
// Reset values and writable masks (reserved bits are held at zero)
// ----------
`define RST_LED_CURRENT 8'h00
`define MASK_LED_CURRENT 8'hFF
`define RST_SLOT2_SELECTS 8'h00
`define MASK_SLOT2_SELECTS 8'h4F
`define RST_SLOT2_CONFIG_ONE 8'h18
`define MASK_SLOT2_CONFIG_ONE 8'hDF
`define RST_SLOT2_CONFIG_TWO 8'h3A
`define MASK_SLOT2_CONFIG_TWO 8'hFF
`define RST_SLOT2_CONFIG_THREE 8'h28
`define MASK_SLOT2_CONFIG_THREE 8'hF8
`define RST_SLOT2_CONFIG_FOUR 8'h00
`define MASK_SLOT2_CONFIG_FOUR 8'h77

// ----------
// Field positions
// ----------
`define SEL_AMBIENT_BIT 6
`define SEL_DRV_B_HI 3
`define SEL_DRV_B_LO 2
`define SEL_DRV_A_HI 1
`define SEL_DRV_A_LO 0
`define CFG1_PD_SEL_HI 7
`define CFG1_PD_SEL_LO 6
`define CFG1_TINT_HI 4
`define CFG1_TINT_LO 3
`define CFG1_AVER_HI 2
`define CFG1_AVER_LO 0
`define CFG2_DECIM_BIT 7
`define CFG2_AMB_METHOD_BIT 6
`define CFG2_LED_RANGE_HI 5
`define CFG2_LED_RANGE_LO 4
`define CFG2_CH2_ADC_HI 3
`define CFG2_CH2_ADC_LO 2
`define CFG2_CH1_ADC_HI 1
`define CFG2_CH1_ADC_LO 0
`define CFG3_PD_SETL_HI 7
`define CFG3_PD_SETL_LO 5
`define CFG3_LED_SETL_HI 4
`define CFG3_LED_SETL_LO 3
`define CFG4_CH2_OFF_HI 6
`define CFG4_CH2_OFF_LO 4
`define CFG4_CH1_OFF_HI 2
`define CFG4_CH1_OFF_LO 0

// ----------
// Scaling: one step is 0.125 mA; full scale per range step is 32 mA
// ----------
`define FULL_SCALE_STEP_MA 8'h20
`define TINT_FOR_DECIMATION 2'h3
`define CODE_OFF 8'h00

`endif

// File: inc/led_meas_pkg.sv
// Types shared by the slot configuration slice.
// Assumes nothing beyond a SystemVerilog compiler.
package led_meas_pkg;

    // LED full-scale range code: 32, 64, 96 or 128 mA
    typedef enum logic [1:0] {
        RANGE_32MA,
        RANGE_64MA,
        RANGE_96MA,
        RANGE_128MA
    } led_range_type;

    // One 8-bit drive-current code
    typedef logic [7:0] current_code_type;

    // Delivered current in 0.125 mA steps
    typedef logic [9:0] current_steps_type;

endpackage

// File: rtl/field_reg.sv
// One 8-bit software register with a reset value and a writable mask.
// Assumes the write strobe is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
`default_nettype none

module field_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic write_strobe,
    input wire logic [7:0] write_data,
    output logic [7:0] value
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Reserved bits never store a one, so they read back as zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            value <= RESET_VALUE;
        end else if (write_strobe) begin
            value <= write_data & WRITE_MASK;
        end
    end

endmodule

`default_nettype wire

// File: rtl/led_current_scaler.sv
// Turns a drive-current code and a range code into the driver's enable,
// its current in 0.125 mA steps and the range's full scale in mA.
// Assumes code and range come from flops on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "led_meas_params.svh"

module led_current_scaler
    import led_meas_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire current_code_type code,
    input wire led_range_type range,
    output logic driver_enable,
    output current_steps_type current_steps,
    output logic [7:0] full_scale_ma
);

    // ----------
    // Scaling
    // ----------
    // Step multiplier is range + 1 (1 to 4 eighths of a mA)
    logic [2:0] range_mult;
    current_steps_type next_current_steps;
    logic [7:0] next_full_scale_ma;
    logic next_driver_enable;

    assign range_mult = {1'b0, range} + 3'h1;
    // Current is code times step; 0xFF at range 3 gives 1020 steps
    assign next_current_steps = {2'h0, code} * {7'h00, range_mult};
    // Full scale grows by 32 mA per range code
    assign next_full_scale_ma = {5'h00, range_mult} * `FULL_SCALE_STEP_MA;
    // A zero code keeps the driver off
    assign next_driver_enable = (code != `CODE_OFF);

    // ----------
    // Output flops
    // ----------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            driver_enable <= 1'b0;
            current_steps <= '0;
            full_scale_ma <= 8'h00;
        end else begin
            driver_enable <= next_driver_enable;
            current_steps <= next_driver_enable ? next_current_steps : '0;
            full_scale_ma <= next_full_scale_ma;
        end
    end

endmodule

`default_nettype wire

// File: rtl/led_meas_config_regs.sv
// Slot configuration register slice of an optical front end: drive-current
// codes, selects and measurement settings behind an Avalon-MM slave port,
// with the drive current of each covered driver worked out in hardware.
// Assumes one 125 MHz clock, a synchronous reset, byte addresses on the bus,
// and that the slot-one range and slot-two driver B code arrive from
// neighbouring register logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "led_meas_params.svh"

module led_meas_config_regs
    import led_meas_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Neighbouring slot settings, same clock
    input wire led_range_type slot1_led_full_scale_range,
    input wire current_code_type slot2_driver_b_current_code,
    // Slot-one driver B
    output current_code_type slot1_driver_b_current_code,
    output logic slot1_led_driver_b_enable,
    output current_steps_type slot1_led_driver_b_steps,
    // Slot-two selects
    output logic slot2_ambient_only,
    output logic [1:0] slot2_led_driver_b_select,
    output logic [1:0] slot2_led_driver_a_select,
    // Slot-two measurement settings
    output logic [1:0] slot2_photodiode_select,
    output logic [1:0] slot2_integration_time,
    output logic [2:0] slot2_averaging,
    output logic slot2_decimation_filter_enable,
    output logic slot2_ambient_method_select,
    output led_range_type slot2_led_full_scale_range,
    output logic [1:0] slot2_chan2_adc_range,
    output logic [1:0] slot2_chan1_adc_range,
    output logic [2:0] slot2_photodiode_settling,
    output logic [1:0] slot2_led_settling,
    output logic [2:0] slot2_chan2_offset_code,
    output logic [2:0] slot2_chan1_offset_code,
    // Slot-two drivers
    output current_code_type slot2_driver_a_current_code,
    output logic slot2_led_driver_a_enable,
    output current_steps_type slot2_led_driver_a_steps,
    output logic slot2_led_driver_b_enable,
    output current_steps_type slot2_led_driver_b_steps,
    output logic [7:0] slot2_full_scale_ma,
    output logic slot2_decimation_config_ok
);

    // ----------
    // Bus handshake
    // ----------
    // Word index taken from the byte address; low two bits are ignored
    wire logic [5:0] addr_index;
    // A request is served once, in the cycle waitrequest stands high
    wire logic serve;
    // Write applies only when the low byte lane is enabled
    wire logic write_low_lane;

    assign addr_index = avs_address[7:2];
    assign serve = (avs_read | avs_write) & avs_waitrequest;
    assign write_low_lane = serve & avs_write & avs_byteenable[0];

    // ----------
    // Address decode
    // ----------
    // One select per mapped word
    wire logic hit_slot1_led_b = (addr_index == `IDX_SLOT1_LED_B_CURRENT);
    wire logic hit_status = (addr_index == `IDX_DRIVE_STATUS);
    wire logic hit_selects = (addr_index == `IDX_SLOT2_SELECTS);
    wire logic hit_config_one = (addr_index == `IDX_SLOT2_CONFIG_ONE);
    wire logic hit_config_two = (addr_index == `IDX_SLOT2_CONFIG_TWO);
    wire logic hit_config_three = (addr_index == `IDX_SLOT2_CONFIG_THREE);
    wire logic hit_config_four = (addr_index == `IDX_SLOT2_CONFIG_FOUR);
    wire logic hit_slot2_led_a = (addr_index == `IDX_SLOT2_LED_A_CURRENT);

    // ----------
    // Register storage
    // ----------
    // Raw register values
    logic [7:0] slot1_led_b_current;
    logic [7:0] slot2_selects;
    logic [7:0] slot2_config_one;
    logic [7:0] slot2_config_two;
    logic [7:0] slot2_config_three;
    logic [7:0] slot2_config_four;
    logic [7:0] slot2_led_a_current;

    // Slot-one driver B code, full 8 bits, reset zero
    field_reg #(
        .RESET_VALUE(`RST_LED_CURRENT),
        .WRITE_MASK(`MASK_LED_CURRENT)
    ) u_slot1_led_b_current (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .write_strobe(write_low_lane & hit_slot1_led_b),
        .write_data(avs_writedata[7:0]),
        .value(slot1_led_b_current)
    );

    // Slot-two selects, bits 7, 5 and 4 reserved
    field_reg #(
        .RESET_VALUE(`RST_SLOT2_SELECTS),
        .WRITE_MASK(`MASK_SLOT2_SELECTS)
    ) u_slot2_selects (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .write_strobe(write_low_lane & hit_selects),
        .write_data(avs_writedata[7:0]),
        .value(slot2_selects)
    );

    // Slot-two config one, bit 5 reserved, integration resets to 3
    field_reg #(
        .RESET_VALUE(`RST_SLOT2_CONFIG_ONE),
        .WRITE_MASK(`MASK_SLOT2_CONFIG_ONE)
    ) u_slot2_config_one (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .write_strobe(write_low_lane & hit_config_one),
        .write_data(avs_writedata[7:0]),
        .value(slot2_config_one)
    );

    // Slot-two config two, range resets to 3 and ADC ranges to 2
    field_reg #(
        .RESET_VALUE(`RST_SLOT2_CONFIG_TWO),
        .WRITE_MASK(`MASK_SLOT2_CONFIG_TWO)
    ) u_slot2_config_two (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .write_strobe(write_low_lane & hit_config_two),
        .write_data(avs_writedata[7:0]),
        .value(slot2_config_two)
    );

    // Slot-two config three, bits 2:0 reserved, settling codes reset to 1
    field_reg #(
        .RESET_VALUE(`RST_SLOT2_CONFIG_THREE),
        .WRITE_MASK(`MASK_SLOT2_CONFIG_THREE)
    ) u_slot2_config_three (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .write_strobe(write_low_lane & hit_config_three),
        .write_data(avs_writedata[7:0]),
        .value(slot2_config_three)
    );

    // Slot-two config four, bits 7 and 3 reserved
    field_reg #(
        .RESET_VALUE(`RST_SLOT2_CONFIG_FOUR),
        .WRITE_MASK(`MASK_SLOT2_CONFIG_FOUR)
    ) u_slot2_config_four (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .write_strobe(write_low_lane & hit_config_four),
        .write_data(avs_writedata[7:0]),
        .value(slot2_config_four)
    );

    // Slot-two driver A code, full 8 bits, reset zero
    field_reg #(
        .RESET_VALUE(`RST_LED_CURRENT),
        .WRITE_MASK(`MASK_LED_CURRENT)
    ) u_slot2_led_a_current (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .write_strobe(write_low_lane & hit_slot2_led_a),
        .write_data(avs_writedata[7:0]),
        .value(slot2_led_a_current)
    );

    // ----------
    // Field split
    // ----------
    // Slot-two range code taken from bits 5:4 of config two
    wire led_range_type slot2_range_field;
    assign slot2_range_field =
        led_range_type'(slot2_config_two[`CFG2_LED_RANGE_HI:`CFG2_LED_RANGE_LO]);

    // Field outputs are wires onto register flops
    assign slot1_driver_b_current_code = slot1_led_b_current;
    assign slot2_ambient_only = slot2_selects[`SEL_AMBIENT_BIT];
    assign slot2_led_driver_b_select = slot2_selects[`SEL_DRV_B_HI:`SEL_DRV_B_LO];
    assign slot2_led_driver_a_select = slot2_selects[`SEL_DRV_A_HI:`SEL_DRV_A_LO];
    assign slot2_photodiode_select = slot2_config_one[`CFG1_PD_SEL_HI:`CFG1_PD_SEL_LO];
    assign slot2_integration_time = slot2_config_one[`CFG1_TINT_HI:`CFG1_TINT_LO];
    assign slot2_averaging = slot2_config_one[`CFG1_AVER_HI:`CFG1_AVER_LO];
    assign slot2_decimation_filter_enable = slot2_config_two[`CFG2_DECIM_BIT];
    assign slot2_ambient_method_select = slot2_config_two[`CFG2_AMB_METHOD_BIT];
    assign slot2_led_full_scale_range = slot2_range_field;
    assign slot2_chan2_adc_range = slot2_config_two[`CFG2_CH2_ADC_HI:`CFG2_CH2_ADC_LO];
    assign slot2_chan1_adc_range = slot2_config_two[`CFG2_CH1_ADC_HI:`CFG2_CH1_ADC_LO];
    assign slot2_photodiode_settling = slot2_config_three[`CFG3_PD_SETL_HI:`CFG3_PD_SETL_LO];
    assign slot2_led_settling = slot2_config_three[`CFG3_LED_SETL_HI:`CFG3_LED_SETL_LO];
    assign slot2_chan2_offset_code = slot2_config_four[`CFG4_CH2_OFF_HI:`CFG4_CH2_OFF_LO];
    assign slot2_chan1_offset_code = slot2_config_four[`CFG4_CH1_OFF_HI:`CFG4_CH1_OFF_LO];
    assign slot2_driver_a_current_code = slot2_led_a_current;

    // ----------
    // Drive-current scaling
    // ----------
    // Slot-one driver B scales by slot one's range from next door
    led_current_scaler u_slot1_drv_b (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .code(slot1_led_b_current),
        .range(slot1_led_full_scale_range),
        .driver_enable(slot1_led_driver_b_enable),
        .current_steps(slot1_led_driver_b_steps),
        .full_scale_ma()
    );

    // Slot-two driver A; also reports the slot's full scale
    led_current_scaler u_slot2_drv_a (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .code(slot2_led_a_current),
        .range(slot2_range_field),
        .driver_enable(slot2_led_driver_a_enable),
        .current_steps(slot2_led_driver_a_steps),
        .full_scale_ma(slot2_full_scale_ma)
    );

    // Slot-two driver B shares the same range as driver A
    led_current_scaler u_slot2_drv_b (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .code(slot2_driver_b_current_code),
        .range(slot2_range_field),
        .driver_enable(slot2_led_driver_b_enable),
        .current_steps(slot2_led_driver_b_steps),
        .full_scale_ma()
    );

    // ----------
    // Decimation setting check
    // ----------
    // The decimation filter only works at the longest integration time
    wire logic next_decimation_config_ok;
    assign next_decimation_config_ok = ~slot2_decimation_filter_enable
        | (slot2_integration_time == `TINT_FOR_DECIMATION);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            slot2_decimation_config_ok <= 1'b1;
        end else begin
            slot2_decimation_config_ok <= next_decimation_config_ok;
        end
    end

    // ----------
    // Read path
    // ----------
    // Read-only status: driver enables and decimation check
    wire logic [7:0] drive_status;
    assign drive_status = {4'h0, slot2_decimation_config_ok, slot2_led_driver_b_enable,
        slot2_led_driver_a_enable, slot1_led_driver_b_enable};

    // Unmapped words read as zero
    wire logic [7:0] read_value;
    assign read_value =
        hit_slot1_led_b ? slot1_led_b_current :
        hit_status ? drive_status :
        hit_selects ? slot2_selects :
        hit_config_one ? slot2_config_one :
        hit_config_two ? slot2_config_two :
        hit_config_three ? slot2_config_three :
        hit_config_four ? slot2_config_four :
        hit_slot2_led_a ? slot2_led_a_current : 8'h00;

    // Waitrequest drops for exactly one cycle per request
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (serve) begin
            // Answer: capture read data, release the master next edge
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? {24'h00_0000, read_value} : 32'h0000_0000;
        end else begin
            // Back to waiting for the next request
            avs_waitrequest <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: tb/led_meas_config_regs_asserts.sv
// Checker for the slot configuration slice: bus answer and drive scaling.
// Assumes it is bound to led_meas_config_regs on core_clk.
`timescale 1ns/1ps
`default_nettype none

module led_meas_config_regs_checker
    import led_meas_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire led_range_type slot1_led_full_scale_range,
    input wire current_code_type slot2_driver_b_current_code,
    input wire current_code_type slot1_driver_b_current_code,
    input wire logic slot1_led_driver_b_enable,
    input wire current_steps_type slot1_led_driver_b_steps,
    input wire led_range_type slot2_led_full_scale_range,
    input wire current_code_type slot2_driver_a_current_code,
    input wire logic slot2_led_driver_a_enable,
    input wire current_steps_type slot2_led_driver_a_steps,
    input wire logic slot2_led_driver_b_enable,
    input wire current_steps_type slot2_led_driver_b_steps,
    input wire logic [7:0] slot2_full_scale_ma
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // Bus answer and register stores
    // ------------------------------------------------------------------
    wire logic wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    wait_pulse_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late or long");
    a_store_a: assert property (wr_done && avs_address == 8'hB4
        |-> slot2_driver_a_current_code == avs_writedata[7:0]) else $error("A code not stored");
    range_store_a: assert property (wr_done && avs_address == 8'hA8
        |-> slot2_led_full_scale_range == avs_writedata[5:4]) else $error("range not stored");

    // ------------------------------------------------------------------
    // Driver enables, steps and full scale, one cycle after their sources
    // ------------------------------------------------------------------
    a_off_a: assert property (!sys_rst |=> slot2_led_driver_a_enable ==
        ($past(slot2_driver_a_current_code) != 8'h00)) else $error("A enable wrong");
    b_off_a: assert property (!sys_rst |=> slot2_led_driver_b_enable ==
        ($past(slot2_driver_b_current_code) != 8'h00)) else $error("B enable wrong");
    a_steps_a: assert property (!sys_rst |=> slot2_led_driver_a_steps ==
        10'($past(slot2_driver_a_current_code)) * (10'($past(slot2_led_full_scale_range)) + 10'd1))
        else $error("A steps wrong");
    b_steps_a: assert property (!sys_rst |=> slot2_led_driver_b_steps ==
        10'($past(slot2_driver_b_current_code)) * (10'($past(slot2_led_full_scale_range)) + 10'd1))
        else $error("B steps wrong");
    slot1_steps_a: assert property (!sys_rst |=> slot1_led_driver_b_steps ==
        10'($past(slot1_driver_b_current_code)) * (10'($past(slot1_led_full_scale_range)) + 10'd1)
        && slot1_led_driver_b_enable == ($past(slot1_driver_b_current_code) != 8'h00))
        else $error("slot one B drive wrong");
    full_scale_a: assert property (!sys_rst |=> slot2_full_scale_ma ==
        8'h20 * (8'($past(slot2_led_full_scale_range)) + 8'h01)) else $error("full scale wrong");

    write_cover: cover property (wr_done && avs_address == 8'hB4);
    read_cover: cover property (avs_read && !avs_waitrequest);
    top_range_cover: cover property (slot2_led_full_scale_range == 2'h3 && slot2_led_driver_a_enable);
endmodule

bind led_meas_config_regs led_meas_config_regs_checker led_meas_config_regs_checker_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .slot1_led_full_scale_range(slot1_led_full_scale_range),
    .slot2_driver_b_current_code(slot2_driver_b_current_code),
    .slot1_driver_b_current_code(slot1_driver_b_current_code),
    .slot1_led_driver_b_enable(slot1_led_driver_b_enable),
    .slot1_led_driver_b_steps(slot1_led_driver_b_steps),
    .slot2_led_full_scale_range(slot2_led_full_scale_range),
    .slot2_driver_a_current_code(slot2_driver_a_current_code),
    .slot2_led_driver_a_enable(slot2_led_driver_a_enable),
    .slot2_led_driver_a_steps(slot2_led_driver_a_steps),
    .slot2_led_driver_b_enable(slot2_led_driver_b_enable),
    .slot2_led_driver_b_steps(slot2_led_driver_b_steps),
    .slot2_full_scale_ma(slot2_full_scale_ma));
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the slot configuration slice.
// Assumes the checker is bound in; registers sit at byte address index*4.
`timescale 1ns/1ps
`default_nettype none

module testbench
    import led_meas_pkg::*;
;
    logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q, e;
    led_range_type r1_in, rng2;
    current_code_type b2_in, a1, a2, b1, ac, bc;
    logic a2e, b2e, b1e, amb, dec, ambm, okd;
    logic [1:0] bs, as_, pd, ti, c2r, c1r, lst;
    logic [2:0] av, pst, o2, o1;
    current_steps_type a2s, b2s, b1s;
    logic [7:0] fs;
    int miscompares = 0, cmp_count = 0, seed = 32'h8C96;
    // Register byte addresses, reset values and writable masks
    logic [7:0] adr [7] = '{8'h98, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4};
    logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h18, 8'h3A, 8'h28, 8'h00, 8'h00};
    logic [7:0] msk [7] = '{8'hFF, 8'h4F, 8'hDF, 8'hFF, 8'hF8, 8'h77, 8'hFF};

    led_meas_config_regs led_meas_config_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .slot1_led_full_scale_range(r1_in), .slot2_driver_b_current_code(b2_in),
        .slot1_driver_b_current_code(b1), .slot1_led_driver_b_enable(b1e),
        .slot1_led_driver_b_steps(b1s), .slot2_ambient_only(amb),
        .slot2_led_driver_b_select(bs), .slot2_led_driver_a_select(as_),
        .slot2_photodiode_select(pd), .slot2_integration_time(ti), .slot2_averaging(av),
        .slot2_decimation_filter_enable(dec), .slot2_ambient_method_select(ambm),
        .slot2_led_full_scale_range(rng2), .slot2_chan2_adc_range(c2r),
        .slot2_chan1_adc_range(c1r), .slot2_photodiode_settling(pst), .slot2_led_settling(lst),
        .slot2_chan2_offset_code(o2), .slot2_chan1_offset_code(o1),
        .slot2_driver_a_current_code(a2), .slot2_led_driver_a_enable(a2e),
        .slot2_led_driver_a_steps(a2s), .slot2_led_driver_b_enable(b2e),
        .slot2_led_driver_b_steps(b2s), .slot2_full_scale_ma(fs),
        .slot2_decimation_config_ok(okd));

    // Clock at 8 ns
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end

    // Field outputs gathered into their register layout
    function automatic logic [7:0] view(input int i);
        case (i)
            0: view = b1;
            1: view = {1'b0, amb, 2'b00, bs, as_};
            2: view = {pd, 1'b0, ti, av};
            3: view = {dec, ambm, rng2, c2r, c1r};
            4: view = {pst, lst, 3'b000};
            5: view = {1'b0, o2, 1'b0, o1};
            default: view = a2;
        endcase
    endfunction

    function automatic logic [9:0] steps(input logic [7:0] c, input logic [1:0] r);
        steps = 10'(c) * (10'(r) + 10'd1);
    endfunction

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
            input logic [3:0] be);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        // Only the watchdog ends a wait that never gets its answer
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hung bus
    initial begin
        #300000;
        miscompares++;
        complete_run();
    end

    // Main sequence
    initial begin
        logic [7:0] d;
        logic [1:0] r;
        sys_rst = 1;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        r1_in = RANGE_32MA;
        b2_in = 8'h00;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Reset values, field outputs, unmapped place
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, adr[i], 8'h00, 4'hF);
            check("reset read", {24'h0, rst[i]}, q);
            check("reset field", 32'(rst[i]), 32'(view(i)));
        end
        bus(1'b0, 8'hFC, 8'h00, 4'hF);
        check("unmapped read", 32'h0, q);
        $display("reset test done");
        // All ones, all zeros, then random data through every register
        for (int k = 0; k < 49; k++) begin
            d = (k < 7) ? 8'hFF : (k < 14) ? 8'h00 : 8'($random(seed));
            bus(1'b1, adr[k % 7], d, 4'hF);
            bus(1'b0, adr[k % 7], 8'h00, 4'hF);
            e = 32'(d & msk[k % 7]);
            check("readback", e, q);
            check("field", e, 32'(view(k % 7)));
            check("decim ok", 32'(!dec || ti == 2'h3), 32'(okd));
        end
        bus(1'b1, 8'hB4, 8'h5A, 4'hF);
        bus(1'b1, 8'hB4, 8'hA5, 4'hE);
        bus(1'b0, 8'hB4, 8'h00, 4'hF);
        check("lane off write", 32'h5A, q);
        $display("register test done");
        // Drive current for every range at the code corners
        for (int k = 0; k < 24; k++) begin
            r = 2'(k / 6);
            ac = (k % 6 == 0) ? 8'h00 : (k % 6 == 1) ? 8'h01 : (k % 6 == 2) ? 8'hFF : 8'($random(seed));
            bc = (k % 6 == 3) ? 8'h00 : 8'($random(seed));
            r1_in <= led_range_type'(r);
            b2_in <= bc;
            bus(1'b1, 8'hA8, {2'b00, r, 4'hA}, 4'hF);
            bus(1'b1, 8'hB4, ac, 4'hF);
            bus(1'b1, 8'h98, ~ac, 4'hF);
            repeat (2) @(posedge core_clk);
            check("A steps", 32'(steps(ac, r)), 32'(a2s));
            check("A on", 32'(ac != 8'h00), 32'(a2e));
            check("B steps", 32'(steps(bc, r)), 32'(b2s));
            check("B on", 32'(bc != 8'h00), 32'(b2e));
            check("slot1 B steps", 32'(steps(~ac, r)), 32'(b1s));
            check("slot1 B on", 32'(~ac != 8'h00), 32'(b1e));
            check("full scale", 32'(8'h20 * (8'(r) + 8'h01)), 32'(fs));
            bus(1'b0, 8'h9C, 8'h00, 4'hF);
            check("status", {28'h0, 1'b1, |bc, |ac, ~&ac}, q);
        end
        $display("drive current test done");
        complete_run();
    end
endmodule
`default_nettype wire
